// *** sfio_top.sv ***
// Serial flash front end: line modes, pause, resets and guard logic
module sfio_top
  import sfio_pkg::*;
#(
  parameter int RST_WAIT = RST_WAIT_CYC
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic sck_in,
  input wire logic cs_n_in,
  input wire logic [3:0] dl_in,
  output logic [3:0] dl_out,
  output logic [3:0] dl_oe_n_out,
  input wire logic rst_pin_n_in,
  input wire logic quad_lines_enable_in,
  input wire logic pause_or_reset_select_in,
  input wire logic [1:0] status_lock_bits_in,
  input wire logic protect_complement_in,
  input wire logic sector_granularity_in,
  input wire logic top_bottom_select_in,
  input wire logic [2:0] block_protect_level_in,
  input wire logic [SECT_BITS-1:0] sector_in,
  input wire logic reply_valid_in,
  input wire logic [7:0] reply_byte_in,
  output logic instr_valid_out,
  output logic [7:0] instr_code_out,
  output logic cmd_mode_out,
  output logic busy_out,
  output logic status_write_block_out,
  output logic sector_locked_out
);
  sfio_xfer_if xf ();

  logic pe_m_q;
  logic pe_s_q;
  logic hold_q;
  logic [5:0] sy_m_q;
  logic [5:0] sy_s_q;
  logic [1:0] rdy_p_q;
  logic seen_high_q;
  logic cmd_mode_q;
  logic rst_armed_q;
  logic [12:0] rst_cnt_q;
  logic valid_q;
  logic [7:0] code_q;
  sfio_lanes_e lanes_q;
  logic rep_rdy_q;
  logic [7:0] rep_byte_q;
  sfio_lanes_e rep_lanes_q;
  logic wblock_q;
  logic locked_q;

  //------------------------------------------------------------
  // Pause on the link clock
  //------------------------------------------------------------
  wire logic pause_cfg_w;
  wire logic hold_w;
  // Pause exists only with quad lines off and the shared pin set to pause
  assign pause_cfg_w = !quad_lines_enable_in && (pause_or_reset_select_in != SEL_RESET);

  // Static configuration levels brought into the link domain
  always_ff @(posedge sck_in) begin
    pe_m_q <= pause_cfg_w;
    pe_s_q <= pe_m_q;
  end

  // Pin level kept from each rising edge, so a high clock freezes the pause state
  always_ff @(posedge sck_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      hold_q <= 1'b0;
    end else begin
      hold_q <= pe_s_q && !dl_in[3];
    end
  end

  // A low clock lets the pin edge act at once
  assign hold_w = !cs_n_in && pe_s_q && (sck_in ? hold_q : !dl_in[3]);

  //------------------------------------------------------------
  // Pins
  //------------------------------------------------------------
  assign xf.rx = dl_in;
  assign xf.hold = hold_w;
  assign xf.rep_rdy = rep_rdy_q;
  assign xf.rep_byte = rep_byte_q;
  assign xf.rep_lanes = rep_lanes_q;
  assign dl_out = xf.tx;
  // Chip select floats the lines without waiting for any clock
  assign dl_oe_n_out = ~(xf.tx_en & {4{!cs_n_in && !hold_w}});

  sfio_shift u_shift (
    .sck_in(sck_in),
    .cs_n_in(cs_n_in),
    .xf(xf)
  );

  //------------------------------------------------------------
  // Synchronisers into the system clock
  //------------------------------------------------------------
  wire logic [5:0] async_w;
  assign async_w = {xf.ser_rdy, xf.cmd_rdy, dl_in[3], dl_in[2], rst_pin_n_in, cs_n_in};

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      sy_m_q <= SYNC_RST;
      sy_s_q <= SYNC_RST;
      rdy_p_q <= 2'h0;
    end else begin
      sy_m_q <= async_w;
      sy_s_q <= sy_m_q;
      rdy_p_q <= sy_s_q[5:4];
    end
  end

  wire logic cs_n_s;
  wire logic rpin_n_s;
  wire logic guard_n_s;
  wire logic p3_s;
  assign cs_n_s = sy_s_q[0];
  assign rpin_n_s = sy_s_q[1];
  assign guard_n_s = sy_s_q[2];
  assign p3_s = sy_s_q[3];

  //------------------------------------------------------------
  // Instruction decode
  //------------------------------------------------------------
  wire logic hw_rst_w;
  wire logic busy_w;
  wire logic ev_w;
  wire logic [7:0] code_w;
  wire logic quad_op_w;
  wire logic dual_op_w;
  wire logic take_w;
  wire logic is_enter_w;
  wire logic is_exit_w;
  wire logic is_rst_en_w;
  wire logic do_rst_w;
  // Dedicated pin always resets; shared pin only when configured for it
  assign hw_rst_w = !rpin_n_s
                 || (!quad_lines_enable_in && pause_or_reset_select_in == SEL_RESET && !p3_s);
  assign busy_w = hw_rst_w || (rst_cnt_q != 13'h0000);
  // The mode picks which reading of the frame is the instruction
  assign ev_w = cmd_mode_q ? (sy_s_q[4] && !rdy_p_q[0]) : (sy_s_q[5] && !rdy_p_q[1]);
  assign code_w = cmd_mode_q ? xf.cmd_code : xf.ser_code;
  assign quad_op_w = code_w == OP_QUAD_OUT || code_w == OP_QUAD_IO;
  assign dual_op_w = code_w == OP_DUAL_OUT || code_w == OP_DUAL_IO;
  // Quad codes without the enable bit are dropped silently
  assign take_w = ev_w && seen_high_q && !busy_w
               && !(quad_op_w && !quad_lines_enable_in);
  assign is_enter_w = take_w && code_w == OP_ENTER_CMD && !cmd_mode_q;
  assign is_exit_w = take_w && code_w == OP_EXIT_CMD && cmd_mode_q;
  assign is_rst_en_w = take_w && code_w == OP_RST_ENABLE;
  assign do_rst_w = take_w && code_w == OP_RST && rst_armed_q;

  // A frame only counts after chip select was seen high
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      seen_high_q <= 1'b0;
    end else if (cs_n_s) begin
      seen_high_q <= 1'b1;
    end
  end

  // One mode bit keeps the two modes exclusive by construction
  always_ff @(posedge sys_clk_in) begin
    if (rst_in || busy_w || do_rst_w) begin
      cmd_mode_q <= 1'b0;
    end else if (is_enter_w && quad_lines_enable_in) begin
      cmd_mode_q <= 1'b1;
    end else if (is_exit_w) begin
      cmd_mode_q <= 1'b0;
    end
  end

  // Any other instruction between the two codes disarms the reset
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      rst_armed_q <= 1'b0;
    end else if (take_w) begin
      rst_armed_q <= is_rst_en_w;
    end
  end

  // Reset period; the figure is a parameter so benches can shorten it
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      rst_cnt_q <= 13'h0000;
    end else if (do_rst_w) begin
      rst_cnt_q <= 13'(RST_WAIT);
    end else if (rst_cnt_q != 13'h0000) begin
      rst_cnt_q <= rst_cnt_q - 13'h0001;
    end
  end

  // Accepted instruction and the lane width its payload uses
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      valid_q <= 1'b0;
      code_q <= 8'h00;
      lanes_q <= SFIO_L1;
    end else begin
      valid_q <= take_w;
      if (take_w) begin
        code_q <= code_w;
        lanes_q <= (cmd_mode_q || quad_op_w) ? SFIO_L4 : (dual_op_w ? SFIO_L2 : SFIO_L1);
      end
    end
  end

  //------------------------------------------------------------
  // Reply handshake
  //------------------------------------------------------------
  // Byte and width stay frozen while ready is up; the shifter reads them
  // only after its own two-stage copy of ready, so no word tears.
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      rep_rdy_q <= 1'b0;
      rep_byte_q <= 8'h00;
      rep_lanes_q <= SFIO_L1;
    end else if (cs_n_s || busy_w) begin
      rep_rdy_q <= 1'b0;
    end else if (reply_valid_in && !rep_rdy_q) begin
      rep_rdy_q <= 1'b1;
      rep_byte_q <= reply_byte_in;
      rep_lanes_q <= lanes_q;
    end
  end

  //------------------------------------------------------------
  // Write guard and protected region
  //------------------------------------------------------------
  wire logic guard_w;
  wire logic [SECT_BITS:0] size_w;
  wire logic [SECT_BITS:0] idx_w;
  wire logic in_w;
  wire logic [2:0] sh_w;
  // Guard pin is a data line once quad lines are enabled
  assign guard_w = !quad_lines_enable_in && !guard_n_s;
  assign sh_w = (block_protect_level_in - 3'h1 > SEC_MAX_SHIFT) ? SEC_MAX_SHIFT : block_protect_level_in - 3'h1;
  assign size_w = (block_protect_level_in == BP_NONE) ? 12'h000
               : (block_protect_level_in == BP_ALL) ? SECT_COUNT
               : sector_granularity_in ? (12'h001 << sh_w)
               : (BLOCK_SECTS << (block_protect_level_in - 3'h1));
  // Top regions are counted down from the last sector
  assign idx_w = top_bottom_select_in ? (SECT_COUNT - 12'h001 - {1'b0, sector_in}) : {1'b0, sector_in};
  assign in_w = idx_w < size_w;

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      wblock_q <= 1'b0;
      locked_q <= 1'b0;
    end else begin
      wblock_q <= status_lock_bits_in[LOCK_LATCH_BIT] || (status_lock_bits_in[LOCK_GUARD_BIT] && guard_w);
      locked_q <= in_w ^ protect_complement_in;
    end
  end

  assign instr_valid_out = valid_q;
  assign instr_code_out = code_q;
  assign cmd_mode_out = cmd_mode_q;
  assign busy_out = busy_w;
  assign status_write_block_out = wblock_q;
  assign sector_locked_out = locked_q;

  //------------------------------------------------------------
  // Checks
  //------------------------------------------------------------
  chk_cs_float: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    cs_n_in |-> dl_oe_n_out == PIN_FLOAT) else $error("lines driven while deselected");

  chk_first_fall: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    instr_valid_out |-> $past(seen_high_q)) else $error("instruction before first select");

  chk_quad_gate: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    take_w && quad_op_w |-> quad_lines_enable_in) else $error("quad code taken without enable");

  chk_enter_needs: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    $rose(cmd_mode_q) |-> $past(quad_lines_enable_in) && $past(code_w) == OP_ENTER_CMD)
    else $error("command mode entered wrongly");

  chk_exit_cmd: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    is_exit_w |=> !cmd_mode_q ##1 !instr_valid_out || !cmd_mode_q) else $error("exit code ignored");

  chk_soft_rst: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    do_rst_w |=> busy_out && !cmd_mode_q && rst_cnt_q == 13'(RST_WAIT)) else $error("soft reset not started");

  chk_busy_deaf: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    busy_out |=> !instr_valid_out) else $error("instruction taken while busy");

  chk_rst_pair: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    do_rst_w |-> rst_armed_q && instr_code_out == OP_RST_ENABLE) else $error("reset without enable");

  chk_guard_blk: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    $stable(status_lock_bits_in) && status_lock_bits_in[LOCK_GUARD_BIT] && !quad_lines_enable_in
    && !guard_n_s ##1 $stable(status_lock_bits_in) |-> status_write_block_out)
    else $error("guard pin failed to block");

  chk_dedicated_rst: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    !rpin_n_s |-> busy_out ##1 !cmd_mode_q && !instr_valid_out) else $error("reset pin ignored");

  chk_pause_float: assert property (@(negedge sck_in) disable iff (cs_n_in)
    hold_q |-> dl_oe_n_out == PIN_FLOAT) else $error("drive during pause");
endmodule

// *** sfio_pkg.sv ***
// Constants shared by the serial flash line-mode front end
//------------------------------------------------------------
//------------------------------------------------------------
package sfio_pkg;
  localparam logic [7:0] OP_DUAL_OUT = 8'h3b;
  localparam logic [7:0] OP_DUAL_IO = 8'hbb;
  localparam logic [7:0] OP_QUAD_OUT = 8'h6b;
  localparam logic [7:0] OP_QUAD_IO = 8'heb;
  localparam logic [7:0] OP_ENTER_CMD = 8'h38;
  localparam logic [7:0] OP_EXIT_CMD = 8'hff;
  localparam logic [7:0] OP_RST_ENABLE = 8'h66;
  localparam logic [7:0] OP_RST = 8'h99;
  localparam int CLK_PERIOD_NS = 4;
  localparam int TRST_NS = 30000;
  localparam int RST_WAIT_CYC = (TRST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] CMD_CODE_EDGES = 4'h2;
  localparam logic [3:0] SPI_CODE_EDGES = 4'h8;
  localparam logic [3:0] MASK_L1 = 4'h2;
  localparam logic [3:0] MASK_L2 = 4'h3;
  localparam logic [3:0] MASK_L4 = 4'hf;
  localparam logic [3:0] PIN_FLOAT = 4'hf;
  localparam logic SEL_RESET = 1'b1;
  localparam int LOCK_LATCH_BIT = 1;
  localparam int LOCK_GUARD_BIT = 0;
  localparam int SECT_BITS = 11;
  localparam logic [SECT_BITS:0] SECT_COUNT = 12'h800;
  localparam logic [SECT_BITS:0] BLOCK_SECTS = 12'h020;
  localparam logic [2:0] BP_NONE = 3'h0;
  localparam logic [2:0] BP_ALL = 3'h7;
  localparam logic [2:0] SEC_MAX_SHIFT = 3'h3;
  // Sync vector order: ser_rdy, cmd_rdy, pin3, pin2, reset pin, chip select
  localparam logic [5:0] SYNC_RST = 6'h0f;
  typedef enum logic [1:0] {SFIO_L1, SFIO_L2, SFIO_L4} sfio_lanes_e;
endpackage

// *** sfio_xfer_if.sv ***
// Signals between the pin-side control and the link-clock shifter
interface sfio_xfer_if;
  import sfio_pkg::*;
  logic [3:0] rx;
  logic hold;
  logic [7:0] ser_code;
  logic [7:0] cmd_code;
  logic ser_rdy;
  logic cmd_rdy;
  logic rep_rdy;
  logic [7:0] rep_byte;
  sfio_lanes_e rep_lanes;
  logic [3:0] tx;
  logic [3:0] tx_en;
  modport ctl (output rx, hold, rep_rdy, rep_byte, rep_lanes,
               input ser_code, cmd_code, ser_rdy, cmd_rdy, tx, tx_en);
  modport shf (input rx, hold, rep_rdy, rep_byte, rep_lanes,
               output ser_code, cmd_code, ser_rdy, cmd_rdy, tx, tx_en);
endinterface

// *** sfio_shift.sv ***
// Link-clock shifter: instruction capture and reply drive
module sfio_shift
  import sfio_pkg::*;
(
  input wire logic sck_in,
  input wire logic cs_n_in,
  sfio_xfer_if.shf xf
);
  logic [3:0] edges_q;
  logic [7:0] ser_q;
  logic [7:0] cmd_q;
  logic ser_rdy_q;
  logic cmd_rdy_q;
  logic rep_m_q;
  logic rep_s_q;
  logic [7:0] out_q;
  logic [3:0] en_q;
  wire logic step_w;
  wire logic l2_w;
  wire logic l4_w;
  wire logic [3:0] mask_w;
  wire logic [3:0] bits_w;
  wire logic [7:0] rot_w;

  //------------------------------------------------------------
  // Lane selection
  //------------------------------------------------------------
  // Counting stops after eight edges; the rest of the frame is payload
  assign step_w = !xf.hold && (edges_q < SPI_CODE_EDGES);
  assign l2_w = xf.rep_lanes == SFIO_L2;
  assign l4_w = xf.rep_lanes == SFIO_L4;
  assign mask_w = l4_w ? MASK_L4 : (l2_w ? MASK_L2 : MASK_L1);
  assign bits_w = l4_w ? out_q[7:4] : (l2_w ? {2'h0, out_q[7:6]} : {2'h0, out_q[7], 1'h0});
  assign rot_w = l4_w ? {out_q[3:0], out_q[7:4]}
               : (l2_w ? {out_q[5:0], out_q[7:6]} : {out_q[6:0], out_q[7]});
  assign xf.ser_code = ser_q;
  assign xf.cmd_code = cmd_q;
  assign xf.ser_rdy = ser_rdy_q;
  assign xf.cmd_rdy = cmd_rdy_q;
  assign xf.tx = bits_w;
  assign xf.tx_en = en_q;

  //------------------------------------------------------------
  // Rising edge capture
  //------------------------------------------------------------
  // Both readings are built at once, so a mode change just before this
  // frame never needs a clock edge to reach this domain first.
  always_ff @(posedge sck_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      edges_q <= 4'h0;
      ser_q <= 8'h00;
      cmd_q <= 8'h00;
      ser_rdy_q <= 1'b0;
      cmd_rdy_q <= 1'b0;
      rep_m_q <= 1'b0;
      rep_s_q <= 1'b0;
    end else begin
      rep_m_q <= xf.rep_rdy;
      rep_s_q <= rep_m_q;
      if (step_w) begin
        edges_q <= edges_q + 4'h1;
        ser_q <= {ser_q[6:0], xf.rx[0]};
        cmd_q <= (edges_q < CMD_CODE_EDGES) ? {cmd_q[3:0], xf.rx} : cmd_q;
        ser_rdy_q <= ser_rdy_q | (edges_q == SPI_CODE_EDGES - 4'h1);
        cmd_rdy_q <= cmd_rdy_q | (edges_q == CMD_CODE_EDGES - 4'h1);
      end
    end
  end

  //------------------------------------------------------------
  // Falling edge drive
  //------------------------------------------------------------
  // The reply byte rotates, so it repeats until the frame ends
  always_ff @(negedge sck_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      out_q <= 8'h00;
      en_q <= 4'h0;
    end else if (!xf.hold && rep_s_q) begin
      en_q <= mask_w;
      out_q <= (en_q == 4'h0) ? xf.rep_byte : rot_w;
    end
  end
endmodule

// *** sfio_host.sv ***
// Host controller model: serial clock, chip select and host side of the data lines
module sfio_host (
  output logic sck_out,
  output logic cs_n_out,
  output logic [3:0] dl_out,
  output logic [3:0] dl_en_out,
  input wire logic [3:0] dl_in,
  input wire logic [3:0] dev_oe_n_in
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam realtime HALF = 62.5;
  logic cpol = 1'b0;

  // Idle bus: deselected, guard and pause pins held high, data lines released
  initial begin
    sck_out = 1'b0;
    cs_n_out = 1'b1;
    dl_out = 4'hf;
    dl_en_out = 4'hc;
  end

  // Clock parked at the mode's idle level before chip select falls
  task automatic sel(input logic mode3);
    cpol = mode3;
    sck_out = mode3;
    #HALF;
    cs_n_out = 1'b0;
    #HALF;
  endtask

  // Clock back at idle level before chip select rises; gap covers 25 system clocks
  task automatic desel();
    if (!cpol) sck_out = 1'b0;
    #HALF;
    cs_n_out = 1'b1;
    dl_en_out = 4'hc;
    dl_out = 4'hf;
    #100;
  endtask

  // Data changes while the clock is low so the device's rising-edge capture sees it settled
  task automatic send(input logic [7:0] code, input logic quad, input int n);
    for (int i = 0; i < n; i++) begin
      sck_out = 1'b0;
      if (quad) begin
        dl_en_out = 4'hf;
        dl_out = code[7-4*i -: 4];
      end else begin
        dl_en_out = 4'hd;
        dl_out[0] = code[7-i];
      end
      #HALF;
      sck_out = 1'b1;
      #HALF;
    end
  endtask

  // Sample just before each rise; gathers the first byte once the device drives
  task automatic clocks(input int n, input int lanes, output logic [7:0] got, output logic [3:0] oe);
    int bits;
    logic [3:0] grp;
    bits = 0;
    got = 8'h00;
    oe = 4'hf;
    dl_en_out = (lanes == 4) ? 4'h0 : 4'hc;
    for (int i = 0; i < n; i++) begin
      sck_out = 1'b0;
      #HALF;
      grp = (lanes == 1) ? {3'h0, dl_in[1]} : (lanes == 2) ? {2'h0, dl_in[1:0]} : dl_in;
      if (dev_oe_n_in[1] == 1'b0 && bits < 8) begin
        if (bits == 0) oe = dev_oe_n_in;
        got = (got << lanes) | {4'h0, grp};
        bits += lanes;
      end
      sck_out = 1'b1;
      #HALF;
    end
  endtask

  // Pause pin pulsed with the clock low; a clock pulse inside must not end it
  task automatic pause(output logic [3:0] oe);
    sck_out = 1'b0;
    #HALF;
    dl_out[3] = 1'b0;
    #20;
    sck_out = 1'b1;
    #HALF;
    oe = dev_oe_n_in;
    sck_out = 1'b0;
    #20;
    dl_out[3] = 1'b1;
    #HALF;
    sck_out = 1'b1;
    #HALF;
  endtask
endmodule

// *** test_serial_flash_io_mode_ctrl.sv ***
// Self-checking bench for the line-mode front end
module test_serial_flash_io_mode_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  import sfio_pkg::*;
  localparam int RWAIT = 1000;
  logic sys_clk, rst, flt, seen, rst_pin_n, qe, prs, cmp, rv, iv, cmd_mode, busy, swb, slk;
  logic h_sck, h_cs_n;
  logic [3:0] h_dl, h_en, dl_o, dl_oe_n;
  wire logic [3:0] dl_in;
  logic [1:0] lock;
  logic [2:0] bp;
  logic sg, tbs;
  logic [10:0] sec;
  logic [7:0] rb, ic, last;
  int n_errors = 0;
  int total_checks = 0;
  logic [7:0] codes [4] = '{8'h3b, 8'hbb, 8'h6b, 8'heb};

  // Device drive wins, then host; a floating line toggles so a stale level never passes
  assign dl_in = (~dl_oe_n & dl_o) | (dl_oe_n & h_en & h_dl) | (dl_oe_n & ~h_en & {4{flt}});

  sfio_host u_sfio_host (.sck_out(h_sck), .cs_n_out(h_cs_n), .dl_out(h_dl), .dl_en_out(h_en),
    .dl_in(dl_in), .dev_oe_n_in(dl_oe_n));

  sfio_top #(.RST_WAIT(RWAIT)) u_sfio_top (.sys_clk_in(sys_clk), .rst_in(rst), .sck_in(h_sck),
    .cs_n_in(h_cs_n), .dl_in(dl_in), .dl_out(dl_o), .dl_oe_n_out(dl_oe_n), .rst_pin_n_in(rst_pin_n),
    .quad_lines_enable_in(qe), .pause_or_reset_select_in(prs), .status_lock_bits_in(lock),
    .protect_complement_in(cmp), .sector_granularity_in(sg), .top_bottom_select_in(tbs),
    .block_protect_level_in(bp), .sector_in(sec), .reply_valid_in(rv), .reply_byte_in(rb),
    .instr_valid_out(iv), .instr_code_out(ic), .cmd_mode_out(cmd_mode), .busy_out(busy),
    .status_write_block_out(swb), .sector_locked_out(slk));

  // ----------------------------------------
  // Clock, floating pattern and pulse catcher
  // ----------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // The pulse lasts one cycle and lands mid-frame, so it is latched here
  always @(posedge sys_clk) begin
    flt <= ~flt;
    if (iv === 1'b1) begin
      seen <= 1'b1;
      last <= ic;
    end
  end

  // ----------------------------------------
  // Compare, access and closing tasks
  // ----------------------------------------
  task automatic chk_flag(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // Whole frame with one instruction, then whether it was taken and which code
  task automatic frame(input logic [7:0] c, input logic q, input logic m3, input logic ok);
    seen = 1'b0;
    u_sfio_host.sel(m3);
    u_sfio_host.send(c, q, q ? 2 : 8);
    u_sfio_host.desel();
    step(1);
    chk_flag(seen, ok);
    if (ok) chk_val(last, c);
  endtask

  // Instruction, reply offer, read back of the first byte and its lanes, optional pause
  task automatic reply(input logic [7:0] c, input logic q, input logic [7:0] b, input int lanes,
                       input logic pz, input logic [3:0] pexp);
    logic [7:0] got;
    logic [3:0] oe;
    u_sfio_host.sel(1'b0);
    u_sfio_host.send(c, q, q ? 2 : 8);
    step(1);
    rb = b;
    rv = 1'b1;
    step(1);
    rv = 1'b0;
    u_sfio_host.clocks(12, lanes, got, oe);
    if (pz) u_sfio_host.pause(oe);
    u_sfio_host.desel();
    step(1);
    chk_val(got, b);
    chk_val({4'h0, oe}, pz ? {4'h0, pexp} : (lanes == 1) ? 8'h0d : (lanes == 2) ? 8'h0c : 8'h00);
  endtask

  task automatic finish_test();
    $display("checks=%0d errors=%0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Watchdog sized well above the roughly 40 us the sequence needs
  initial begin
    #300000;
    n_errors++;
    finish_test();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst = 1'b1;
    flt = 1'b0;
    seen = 1'b0;
    last = 8'h00;
    {rst_pin_n, qe, prs, cmp, rv, lock, bp, rb} = {1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 2'h0, 3'h0, 8'h00};
    {sg, tbs, sec} = {1'b0, 1'b0, 11'h000};
    step(6);
    rst = 1'b0;
    step(10);
    chk_val({4'h0, dl_oe_n}, 8'h0f);
    chk_flag(cmd_mode, 1'b0);
    frame(8'h05, 1'b0, 1'b0, 1'b1);
    frame(8'h9f, 1'b0, 1'b1, 1'b1);
    u_sfio_host.sel(1'b0);
    u_sfio_host.send(8'h05, 1'b0, 4);
    seen = 1'b0;
    u_sfio_host.desel();
    chk_flag(seen, 1'b0);
    frame(8'h06, 1'b0, 1'b0, 1'b1);
    frame(OP_QUAD_OUT, 1'b0, 1'b0, 1'b0);
    frame(OP_ENTER_CMD, 1'b0, 1'b0, 1'b1);
    chk_flag(cmd_mode, 1'b0);
    reply(8'h05, 1'b0, 8'ha5, 1, 1'b1, 4'hf);
    qe = 1'b1;
    reply(8'h05, 1'b0, 8'h5a, 1, 1'b1, 4'hd);
    for (int i = 0; i < 4; i++) reply(codes[i], 1'b0, 8'h96 + 8'(i), (i < 2) ? 2 : 4, 1'b0, 4'h0);
    frame(OP_ENTER_CMD, 1'b0, 1'b0, 1'b1);
    chk_flag(cmd_mode, 1'b1);
    frame(8'h0b, 1'b1, 1'b0, 1'b1);
    reply(8'h0b, 1'b1, 8'h3c, 4, 1'b0, 4'h0);
    frame(OP_EXIT_CMD, 1'b1, 1'b0, 1'b1);
    chk_flag(cmd_mode, 1'b0);
    // Resets: dedicated pin, shared pin, then the two-instruction software reset
    rst_pin_n = 1'b0;
    step(4);
    chk_flag(busy, 1'b1);
    frame(8'h05, 1'b0, 1'b0, 1'b0);
    rst_pin_n = 1'b1;
    u_sfio_host.dl_out[3] = 1'b0;
    step(4);
    chk_flag(busy, 1'b0);
    qe = 1'b0;
    prs = SEL_RESET;
    step(4);
    chk_flag(busy, 1'b1);
    prs = 1'b0;
    step(4);
    chk_flag(busy, 1'b0);
    u_sfio_host.dl_out[3] = 1'b1;
    qe = 1'b1;
    frame(OP_ENTER_CMD, 1'b0, 1'b0, 1'b1);
    frame(OP_RST_ENABLE, 1'b1, 1'b0, 1'b1);
    frame(OP_RST, 1'b1, 1'b0, 1'b1);
    chk_flag(cmd_mode, 1'b0);
    chk_flag(busy, 1'b1);
    frame(8'h05, 1'b0, 1'b0, 1'b0);
    step(RWAIT);
    chk_flag(busy, 1'b0);
    frame(OP_RST_ENABLE, 1'b0, 1'b0, 1'b1);
    frame(8'h05, 1'b0, 1'b0, 1'b1);
    frame(OP_RST, 1'b0, 1'b0, 1'b1);
    chk_flag(busy, 1'b0);
    // Status write guard and protected region
    lock = 2'h1;
    u_sfio_host.dl_out[2] = 1'b0;
    step(6);
    chk_flag(swb, 1'b0);
    qe = 1'b0;
    step(6);
    chk_flag(swb, 1'b1);
    lock = 2'h2;
    u_sfio_host.dl_out[2] = 1'b1;
    bp = BP_ALL;
    step(6);
    chk_flag(swb, 1'b1);
    chk_flag(slk, 1'b1);
    lock = 2'h0;
    bp = BP_NONE;
    step(6);
    chk_flag(swb, 1'b0);
    chk_flag(slk, 1'b0);
    cmp = 1'b1;
    step(6);
    chk_flag(slk, 1'b1);
    // Single-sector region at the bottom, then counted from the top, then a 32-sector block from the top
    cmp = 1'b0;
    sg = 1'b1;
    bp = 3'h1;
    step(6);
    chk_flag(slk, 1'b1);
    sec = 11'h001;
    step(6);
    chk_flag(slk, 1'b0);
    tbs = 1'b1;
    sec = 11'h7ff;
    step(6);
    chk_flag(slk, 1'b1);
    sg = 1'b0;
    sec = 11'h7e0;
    step(6);
    chk_flag(slk, 1'b1);
    finish_test();
  end
endmodule
